// ===== design/arc_pkg.sv
// package: constants and types for the converter capture controller
package arc_pkg;
    localparam int unsigned    RES_BITS        = 12;
    localparam int unsigned    CLK_PERIOD_NS   = 50;
    localparam int unsigned    TRIG_MAX_NS     = 50;
    // longest time rounds down, never below one cycle
    localparam int unsigned    TRIG_HIGH_CYC   = (TRIG_MAX_NS / CLK_PERIOD_NS) < 1 ? 1
                                                 : (TRIG_MAX_NS / CLK_PERIOD_NS);
    localparam logic [11:0]    CODE_ZERO       = 12'h000;
    localparam logic [11:0]    CODE_FULL       = 12'hFFF;
    localparam logic [11:0]    TWOS_NEG_FULL   = 12'h800;
    localparam logic [11:0]    TWOS_POS_FULL   = 12'h7FF;
    localparam int unsigned    MSB_POS         = 11;
    localparam logic [1:0]     RANGE_IN        = 2'h0;
    localparam logic [1:0]     RANGE_UNDER     = 2'h1;
    localparam logic [1:0]     RANGE_OVER      = 2'h2;
    // strobe idles high, so its synchroniser and edge detector start high: no false edge after reset
    localparam logic [14:0]    SYNC_RESET      = 15'h5000;
    localparam logic           STROBE_IDLE     = 1'b1;
    localparam logic           MSB_INV_IDLE    = 1'b1;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_TRIG = 2'b01,
        ST_WAIT = 2'b11,
        ST_DONE = 2'b10
    } arc_state_type;
endpackage

// ===== design/arc_sync_if.sv
// interface: raw and synchronised pin levels between the top and the synchroniser
`timescale 1ns/10ps
`default_nettype none
interface arc_sync_if;
    logic [11:0] word_raw;
    logic        strobe_raw;
    logic        flag_raw;
    logic        msb_inv_raw;
    logic [11:0] word_s;
    logic        strobe_s;
    logic        flag_s;
    logic        msb_inv_s;
    modport sync (input word_raw, strobe_raw, flag_raw, msb_inv_raw, output word_s, strobe_s, flag_s, msb_inv_s);
    modport top  (output word_raw, strobe_raw, flag_raw, msb_inv_raw, input word_s, strobe_s, flag_s, msb_inv_s);
endinterface
`default_nettype wire

// ===== design/arc_sync.sv
// two-flop synchroniser for the converter output pins
`timescale 1ns/10ps
`default_nettype none
module arc_sync
    import arc_pkg::*;
(
    // clock and reset
    input  wire logic  clk_sys_i,
    input  wire logic  rst_i,
    // pin levels
    arc_sync_if.sync   pins
);
    logic [14:0] meta_r;
    logic [14:0] sync_r;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            meta_r <= SYNC_RESET;
            sync_r <= SYNC_RESET;
        end
        else
        begin
            meta_r <= {pins.msb_inv_raw, pins.flag_raw, pins.strobe_raw, pins.word_raw};
            sync_r <= meta_r;
        end
    end

    assign pins.word_s   = sync_r[11:0];
    assign pins.strobe_s = sync_r[12];
    assign pins.flag_s   = sync_r[13];
    assign pins.msb_inv_s = sync_r[14];
endmodule
`default_nettype wire

// ===== design/arc_capture.sv
// host-side controller: triggers conversions and captures result, range and codings
// Operation
// - capture new word on strobe rising edge
// - falling-edge capture yields previous result (here take_previous_i picks the word held before the rise)
// - decode flag with msb into under/over
// - twos complement uses inverted msb
// - start conversion by raising the trigger
// - drop trigger within 50 ns
`timescale 1ns/10ps
`default_nettype none
module arc_capture
    import arc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // user side
    input  wire logic        start_i,
    input  wire logic        twos_comp_i,
    input  wire logic        take_previous_i,
    output var  logic        busy_o,
    output var  logic        result_valid_o,
    output var  logic [11:0] result_o,
    output var  logic        range_exceeded_o,
    output var  logic [1:0]  range_status_o,
    // converter pins
    output var  logic        conversion_trigger_o,
    input  wire logic [11:0] result_word_i,
    input  wire logic        msb_inv_i,
    input  wire logic        result_valid_strobe_i,
    input  wire logic        range_exceeded_flag_i
);
    arc_sync_if s_if ();

    arc_state_type state_r;
    arc_state_type state_nxt;
    logic [3:0]    trig_cnt_r;
    logic          strobe_d_r;
    logic [11:0]   word_d_r;
    logic          rise;
    logic          fall;
    logic [11:0]   word_sel;
    logic [11:0]   coded;
    logic          inv_d_r;
    logic          low_seen_r;
    logic          inv_sel;

    // every converter pin goes through the synchroniser together
    assign s_if.word_raw    = result_word_i;
    assign s_if.strobe_raw  = result_valid_strobe_i;
    assign s_if.flag_raw    = range_exceeded_flag_i;
    assign s_if.msb_inv_raw = msb_inv_i;

    arc_sync u_sync
    (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pins      (s_if)
    );

    assign rise = s_if.strobe_s & ~strobe_d_r;
    assign fall = ~s_if.strobe_s & strobe_d_r;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            strobe_d_r <= STROBE_IDLE;
            word_d_r   <= CODE_ZERO;
            inv_d_r    <= MSB_INV_IDLE;
        end
        else
        begin
            strobe_d_r <= s_if.strobe_s;
            word_d_r   <= s_if.word_s;
            inv_d_r    <= s_if.msb_inv_s;
        end
    end

    // sequencer
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (start_i)
                    state_nxt = ST_TRIG;
            ST_TRIG:
                if (trig_cnt_r == 4'(TRIG_HIGH_CYC - 1))
                    state_nxt = ST_WAIT;
            // a rise counts only once this conversion's strobe has dropped
            ST_WAIT:
                if (rise && low_seen_r)
                    state_nxt = ST_DONE;
            ST_DONE:
                state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            trig_cnt_r <= 4'h0;
        else if (state_r == ST_TRIG)
            trig_cnt_r <= trig_cnt_r + 4'h1;
        else
            trig_cnt_r <= 4'h0;
    end

    // set wins over the idle clear
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            low_seen_r <= 1'b0;
        else if (fall)
            low_seen_r <= 1'b1;
        else if (state_r == ST_IDLE)
            low_seen_r <= 1'b0;
    end

    // trigger high for one cycle only, 50 ns, which just fills the 50 ns noise window
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            conversion_trigger_o <= 1'b0;
        else
            conversion_trigger_o <= (state_nxt == ST_TRIG);
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            busy_o <= 1'b0;
        else
            busy_o <= (state_nxt == ST_TRIG) || (state_nxt == ST_WAIT);
    end

    // previous word is the one held before the strobe rose
    assign word_sel = take_previous_i ? word_d_r : s_if.word_s;
    assign inv_sel  = take_previous_i ? inv_d_r : s_if.msb_inv_s;
    // twos coding takes the inverted msb pin, so saturated codes read 800/7FF
    assign coded    = twos_comp_i ? {inv_sel, word_sel[MSB_POS-1:0]} : word_sel;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            result_o <= CODE_ZERO;
        else if (rise)
            result_o <= coded;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            range_exceeded_o <= 1'b0;
        else if (rise)
            range_exceeded_o <= s_if.flag_s;
    end

    // status uses the raw msb, before any recoding
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            range_status_o <= RANGE_IN;
        else if (rise)
        begin
            if (!s_if.flag_s)
                range_status_o <= RANGE_IN;
            else if (word_sel[MSB_POS])
                range_status_o <= RANGE_OVER;
            else
                range_status_o <= RANGE_UNDER;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            result_valid_o <= 1'b0;
        else
            result_valid_o <= rise;
    end
endmodule
`default_nettype wire

// ===== tb/arc_capture_checker.sv
// port assertions for the capture controller
`timescale 1ns/10ps
`default_nettype none
module arc_capture_checker
    import arc_pkg::*;
(
    // watched ports
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        start_i,
    input wire logic        twos_comp_i,
    input wire logic        take_previous_i,
    input wire logic        busy_o,
    input wire logic        result_valid_o,
    input wire logic [11:0] result_o,
    input wire logic        range_exceeded_o,
    input wire logic [1:0]  range_status_o,
    input wire logic        conversion_trigger_o,
    input wire logic [11:0] result_word_i,
    input wire logic        msb_inv_i,
    input wire logic        result_valid_strobe_i,
    input wire logic        range_exceeded_flag_i
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_trig_short:
        assert property ($rose(conversion_trigger_o) |=> !conversion_trigger_o) else $error("trigger too long");
    a_trig_cause:
        assert property ($rose(conversion_trigger_o) |-> $past(start_i) && busy_o) else $error("stray trigger");
    a_capture_lag:
        assert property ($rose(result_valid_strobe_i) |-> ##3 result_valid_o) else $error("capture late");
    a_valid_pulse:
        assert property (result_valid_o |=> !result_valid_o) else $error("valid too long");
    a_new_word:
        assert property (result_valid_o && !take_previous_i |->
            result_o == ($past(result_word_i, 3) ^ {twos_comp_i, 11'h000})) else $error("bad word");
    a_flag_copy:
        assert property (result_valid_o |-> range_exceeded_o == $past(range_exceeded_flag_i, 3)) else $error("bad flag");
    a_range_code:
        assert property (result_valid_o && !take_previous_i |-> range_status_o == (!range_exceeded_o ? RANGE_IN
            : $past(result_word_i[MSB_POS], 3) ? RANGE_OVER : RANGE_UNDER)) else $error("bad status");
    a_twos_msb:
        assert property (result_valid_o && twos_comp_i && !take_previous_i |->
            result_o[MSB_POS] == $past(msb_inv_i, 3)) else $error("bad twos msb");
    a_busy_clear:
        assert property (result_valid_o |-> !busy_o) else $error("busy after capture");
    c_over: cover property (result_valid_o && range_status_o == RANGE_OVER);
    c_under: cover property (result_valid_o && range_status_o == RANGE_UNDER);
    c_twos: cover property (result_valid_o && twos_comp_i);
endmodule
bind arc_capture arc_capture_checker arc_capture_checker_i (.*);
`default_nettype wire

// ===== tb/arc_conv_model.sv
// behavioural converter: result word, strobe and range flag
`timescale 1ns/10ps
`default_nettype none
module arc_conv_model
    import arc_pkg::*;
(
    // trigger and test stimulus
    input  wire logic        conversion_trigger_i,
    input  wire logic [11:0] level_i,
    input  wire logic [1:0]  span_i,
    input  wire logic        slow_i,
    // converter pins
    output var  logic [11:0] result_word_o,
    output var  logic        msb_inv_o,
    output var  logic        result_valid_strobe_o,
    output var  logic        range_exceeded_flag_o
);
    assign msb_inv_o = ~result_word_o[MSB_POS];
    initial
    begin
        result_word_o = CODE_ZERO;
        result_valid_strobe_o = 1'h1;
        range_exceeded_flag_o = 1'h0;
    end
    // word moves with the strobe so the old word stays one cycle earlier
    always @(posedge conversion_trigger_i)
    begin
        #20 result_valid_strobe_o = 1'h0;
        #(slow_i ? 2000 : 400);
        result_word_o = span_i == RANGE_OVER ? CODE_FULL : span_i == RANGE_UNDER ? CODE_ZERO : level_i;
        range_exceeded_flag_o = span_i != RANGE_IN;
        result_valid_strobe_o = 1'h1;
    end
endmodule
`default_nettype wire

// ===== tb/arc_capture_tb.sv
// self-checking bench for the capture controller
`timescale 1ns/10ps
`default_nettype none
module arc_capture_tb
    import arc_pkg::*;
;
    logic clk = 0, rst = 1, start = 0, tw = 0, pv = 0, sl = 0, trig, msbn, stb, flg, rv, bsy, rx;
    logic [11:0] lvl = 0, word, res;
    logic [1:0] sp = 0, rs;
    int num_errors = 0, checks = 0;
    initial forever #25 clk = ~clk;
    arc_capture arc_capture_i (.clk_sys_i(clk), .rst_i(rst), .start_i(start), .twos_comp_i(tw),
        .take_previous_i(pv), .busy_o(bsy), .result_valid_o(rv), .result_o(res), .range_exceeded_o(rx),
        .range_status_o(rs), .conversion_trigger_o(trig), .result_word_i(word), .msb_inv_i(msbn),
        .result_valid_strobe_i(stb), .range_exceeded_flag_i(flg));
    arc_conv_model arc_conv_model_i (.conversion_trigger_i(trig), .level_i(lvl), .span_i(sp), .slow_i(sl),
        .result_word_o(word), .msb_inv_o(msbn), .result_valid_strobe_o(stb), .range_exceeded_flag_o(flg));
    task automatic chk(input string nm, input logic [11:0] e, g);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // extra edge first: a start in the cycle after capture is ignored
    task automatic conv(input logic [11:0] l, input logic [1:0] s, input logic t, p, input logic [11:0] e,
        input logic [1:0] es);
        int n;
        @(posedge clk) #5;
        {lvl, sp, tw, pv, start} = {l, s, t, p, 1'h1};
        @(posedge clk) #5 start = 1'h0;
        for (n = 0; n < 200 && rv !== 1'h1; n++) @(posedge clk) #5;
        if (n == 200) num_errors++;
        chk("result", e, res);
        chk("flag", {11'h000, es != RANGE_IN}, {11'h000, rx});
        chk("status", {10'h000, es}, {10'h000, rs});
        chk("busy", 12'h000, {11'h000, bsy});
    endtask
    task t_binary;
        conv(12'h000, RANGE_IN, 1'h0, 1'h0, CODE_ZERO, RANGE_IN);
        conv(12'hFFF, RANGE_IN, 1'h0, 1'h0, CODE_FULL, RANGE_IN);
    endtask
    task t_range;
        sl = 1'h1;
        conv(12'h5A5, RANGE_OVER, 1'h0, 1'h0, CODE_FULL, RANGE_OVER);
        sl = 1'h0;
        conv(12'h5A5, RANGE_UNDER, 1'h0, 1'h0, CODE_ZERO, RANGE_UNDER);
        conv(12'h123, RANGE_IN, 1'h0, 1'h0, 12'h123, RANGE_IN);
    endtask
    task t_twos;
        conv(12'h5A5, RANGE_OVER, 1'h1, 1'h0, TWOS_POS_FULL, RANGE_OVER);
        conv(12'h5A5, RANGE_UNDER, 1'h1, 1'h0, TWOS_NEG_FULL, RANGE_UNDER);
        conv(12'h9C3, RANGE_IN, 1'h1, 1'h0, 12'h1C3, RANGE_IN);
    endtask
    task t_prev;
        conv(12'h456, RANGE_IN, 1'h0, 1'h0, 12'h456, RANGE_IN);
        conv(12'h789, RANGE_IN, 1'h0, 1'h1, 12'h456, RANGE_IN);
    endtask
    task end_sim;
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        #5 rst = 1'h0;
        t_binary;
        t_range;
        t_twos;
        t_prev;
        end_sim;
    end
    initial
    begin
        #100000;
        num_errors++;
        end_sim;
    end
endmodule
`default_nettype wire
